/* File: rtl/trpg_pkg.sv */
package trpg_pkg;
  localparam int CLK_HZ = 50_000_000;
  localparam int RAMP_STEP_MS = 10;
  localparam int RAMP_STEP_CYCLES = CLK_HZ / 1000 * RAMP_STEP_MS;
  localparam logic [25:0] HALF_CLK_HZ = 26'(CLK_HZ / 2);
  localparam int ADDR_W = 8;
  localparam int WORD_W = 16;
  localparam int FREQ_W = 17;
  localparam int DIV_W = 21;
  // Word offsets inside the parameter block
  localparam logic [3:0] OFS_MODE = 4'h0;
  localparam logic [3:0] OFS_STEADY = 4'h1;
  localparam logic [3:0] OFS_INIT = 4'h2;
  localparam logic [3:0] OFS_RAMP = 4'h3;
  localparam logic [3:0] OFS_DIR_MODE = 4'h4;
  localparam logic [3:0] OFS_DIR = 4'h5;
  localparam logic [3:0] OFS_TGT_HI = 4'h6;
  localparam logic [3:0] OFS_TGT_LO = 4'h7;
  localparam logic [3:0] OFS_RUN_HI = 4'h8;
  localparam logic [3:0] OFS_RUN_LO = 4'h9;
  localparam logic [3:0] OFS_ERR = 4'hA;
  localparam logic [3:0] OFS_STATUS = 4'hB;
  localparam logic [3:0] OFS_OPTION = 4'hC;
  localparam int CFG_WORDS = 8;
  // Range mode units and legal limits
  localparam logic [15:0] MODE_TIMED = 16'h0003;
  localparam logic [15:0] PCT_MIN = 16'h0001;
  localparam logic [15:0] PCT_MAX = 16'h0064;
  localparam logic [15:0] TEN_HZ_MIN = 16'h0014;
  localparam logic [15:0] TEN_HZ_MAX = 16'h2710;
  localparam logic [15:0] TIME_MIN = 16'h000A;
  localparam logic [15:0] TIME_MAX = 16'h2710;
  localparam logic [31:0] COUNT_MAX = 32'h05F5E100;
  localparam logic [31:0] HZ_PER_TEN = 32'h0000000A;
  localparam logic [31:0] DIV_SCALE = 32'h0000000A;
  // Error codes
  localparam logic [15:0] ERR_NONE = 16'h0000;
  localparam logic [15:0] ERR_MODE = 16'h0001;
  localparam logic [15:0] ERR_STEADY = 16'h0002;
  localparam logic [15:0] ERR_INIT = 16'h0003;
  localparam logic [15:0] ERR_RAMP = 16'h0004;
  localparam logic [15:0] ERR_DIR = 16'h0005;
  localparam logic [15:0] ERR_COUNT = 16'h0006;
  localparam logic [15:0] ERR_ORDER = 16'h0007;
  // Status flag positions
  localparam int FLAG_ON = 0;
  localparam int FLAG_DONE = 1;
  localparam int FLAG_OVER = 2;
  localparam int FLAG_ERR = 3;
  typedef enum logic [2:0] {
    TRPG_IDLE = 3'b000,
    TRPG_PREP = 3'b001,
    TRPG_ACCEL = 3'b010,
    TRPG_STEADY = 3'b011,
    TRPG_DECEL = 3'b100,
    TRPG_DONE = 3'b101,
    TRPG_FAULT = 3'b110
  } trpg_state_t;
endpackage

/* File: rtl/trpg_top.sv */
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module trpg_top #(
  parameter int TICK_CYCLES = trpg_pkg::RAMP_STEP_CYCLES,
  parameter logic [7:0] PARAM_BASE = 8'h00
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Start pin
  input wire logic start_in,
  // Register port
  input wire logic [trpg_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [trpg_pkg::WORD_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [trpg_pkg::WORD_W-1:0] reg_rdata,
  // Pulse and status
  output logic ramp_pulse_output,
  output logic [3:0] status_flags
);
  import trpg_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    trpg_state_t st;
    logic [CFG_WORDS-1:0][WORD_W-1:0] cfg;
    logic swap;
    logic [WORD_W-1:0] rdata;
    logic sync1;
    logic sync2;
    logic start_d;
    logic pulse;
    logic [25:0] acc;
    logic [FREQ_W-1:0] freq;
    logic [FREQ_W-1:0] step;
    logic [19:0] tick_cnt;
    logic [31:0] pcount;
    logic [31:0] accel_pulses;
    logic [WORD_W-1:0] err;
    logic [3:0] flags;
    logic [DIV_W-1:0] dvd;
    logic [DIV_W-1:0] rem;
    logic [4:0] iter;
  } trpg_regs_t;

  trpg_regs_t s_r;
  trpg_regs_t s_nxt;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Range mode to frequency
  function automatic logic [FREQ_W-1:0] freq_of(input logic [15:0] mode,
                                                input logic [15:0] val);
    logic [31:0] hz;
    hz = 32'h0;
    unique case (mode[1:0])
      2'b00: hz = {16'h0, val} * 32'h0000000A;
      2'b01: hz = {16'h0, val} * 32'h00000064;
      2'b10: hz = {16'h0, val} * 32'h000003E8;
      2'b11: hz = {16'h0, val} * HZ_PER_TEN;
    endcase
    return hz[FREQ_W-1:0];
  endfunction

  function automatic logic in_rng(input logic [15:0] v,
                                  input logic [15:0] lo,
                                  input logic [15:0] hi);
    return (v >= lo) && (v <= hi);
  endfunction

  // Codes 0..7 only, inside both spans
  // Parameter validation, first failing word wins
  function automatic logic [15:0] err_of(input trpg_regs_t s,
                                         input logic [31:0] tgt);
    logic timed;
    logic [15:0] lo;
    logic [15:0] hi;
    timed = (s.cfg[OFS_MODE] == MODE_TIMED);
    lo = timed ? TEN_HZ_MIN : PCT_MIN;
    hi = timed ? TEN_HZ_MAX : PCT_MAX;
    if (s.cfg[OFS_MODE] > MODE_TIMED)
      return ERR_MODE;
    if (!in_rng(s.cfg[OFS_STEADY], lo, hi))
      return ERR_STEADY;
    if (!in_rng(s.cfg[OFS_INIT], lo, hi))
      return ERR_INIT;
    if (timed ? !in_rng(s.cfg[OFS_RAMP], TIME_MIN, TIME_MAX)
              : !in_rng(s.cfg[OFS_RAMP], PCT_MIN, PCT_MAX))
      return ERR_RAMP;
    if (s.cfg[OFS_DIR_MODE] != 16'h0)
      return ERR_DIR;
    if (tgt == 32'h0 || tgt > COUNT_MAX)
      return ERR_COUNT;
    if (s.cfg[OFS_INIT] > s.cfg[OFS_STEADY])
      return ERR_ORDER;
    return ERR_NONE;
  endfunction

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  logic start;
  logic rise;
  logic running;
  logic tick;
  logic [31:0] target;
  logic [31:0] remaining;
  logic [FREQ_W-1:0] f_init;
  logic [FREQ_W-1:0] f_steady;
  logic [3:0] idx;
  logic [7:0] rel;
  logic [26:0] acc_sum;
  logic toggle;
  logic [DIV_W-1:0] rem_t;
  logic [WORD_W-1:0] check;
  logic [FREQ_W:0] up_sum;
  logic [FREQ_W:0] dn_floor;

  assign start = s_r.sync2;
  assign rise = start && !s_r.start_d;
  assign running = (s_r.st == TRPG_ACCEL) || (s_r.st == TRPG_STEADY) ||
                   (s_r.st == TRPG_DECEL);
  assign target = s_r.swap ? {s_r.cfg[OFS_TGT_LO], s_r.cfg[OFS_TGT_HI]}
                           : {s_r.cfg[OFS_TGT_HI], s_r.cfg[OFS_TGT_LO]};
  assign remaining = target - s_r.pcount;
  // Both frequency words share one encoding
  assign f_init = freq_of(s_r.cfg[OFS_MODE], s_r.cfg[OFS_INIT]);
  assign f_steady = freq_of(s_r.cfg[OFS_MODE], s_r.cfg[OFS_STEADY]);
  // Block is addressed relative to its base word
  assign rel = reg_addr - PARAM_BASE;
  assign idx = rel[3:0];
  assign tick = running && (s_r.tick_cnt == 20'(TICK_CYCLES - 1));
  assign acc_sum = {1'b0, s_r.acc} + {10'h0, s_r.freq};
  assign toggle = running && (acc_sum >= {1'b0, HALF_CLK_HZ});
  assign rem_t = {s_r.rem[DIV_W-2:0], s_r.dvd[DIV_W-1]};
  assign check = err_of(s_r, target);
  // One bit wider: a fast ramp near the top must not wrap
  assign up_sum = {1'b0, s_r.freq} + {1'b0, s_r.step};
  assign dn_floor = {1'b0, f_init} + {1'b0, s_r.step};

  always_comb begin
    s_nxt = s_r;
    // Second stage alone reads the first
    s_nxt.sync1 = start_in;
    s_nxt.sync2 = s_r.sync1;
    s_nxt.start_d = start;
    // Register writes; read-only words ignore writes
    if (reg_wr && rel[7:4] == 4'h0) begin
      if (idx < 4'(CFG_WORDS))
        s_nxt.cfg[idx[2:0]] = reg_wdata;
      else if (idx == OFS_OPTION)
        s_nxt.swap = reg_wdata[0];
    end
    s_nxt.rdata = 16'h0;
    if (reg_rd && rel[7:4] == 4'h0) begin
      if (idx < 4'(CFG_WORDS))
        s_nxt.rdata = s_r.cfg[idx[2:0]];
      else if (idx == OFS_RUN_HI)
        s_nxt.rdata = s_r.swap ? s_r.pcount[15:0] : s_r.pcount[31:16];
      else if (idx == OFS_RUN_LO)
        s_nxt.rdata = s_r.swap ? s_r.pcount[31:16] : s_r.pcount[15:0];
      else if (idx == OFS_ERR)
        s_nxt.rdata = s_r.err;
      else if (idx == OFS_STATUS)
        s_nxt.rdata = {12'h0, s_r.flags};
      else if (idx == OFS_OPTION)
        s_nxt.rdata = {15'h0, s_r.swap};
    end
    s_nxt.tick_cnt = (running && !tick) ? s_r.tick_cnt + 20'h1 : 20'h0;
    // Phase accumulator toggles each half period
    if (running) begin
      s_nxt.acc = toggle ? 26'(acc_sum - {1'b0, HALF_CLK_HZ})
                         : acc_sum[25:0];
      if (toggle)
        s_nxt.pulse = !s_r.pulse;
    end
    if (!start) begin
      // Output dropped as soon as start falls
      s_nxt.pulse = 1'b0;
      if (running) begin
        s_nxt.flags[FLAG_ON] = 1'b0;
        s_nxt.flags[FLAG_DONE] = 1'b1;
      end
      s_nxt.st = TRPG_IDLE;
    end else if (rise) begin
      // Fresh cycle from the initial frequency
      s_nxt.err = check;
      s_nxt.pcount = 32'h0;
      s_nxt.accel_pulses = 32'h0;
      s_nxt.acc = 26'h0;
      s_nxt.pulse = 1'b0;
      s_nxt.freq = f_init;
      s_nxt.flags = 4'h0;
      s_nxt.dvd = DIV_W'({16'h0, f_steady - f_init} * DIV_SCALE);
      s_nxt.rem = '0;
      s_nxt.iter = 5'h0;
      s_nxt.step = freq_of(s_r.cfg[OFS_MODE], s_r.cfg[OFS_RAMP]);
      if (check != ERR_NONE) begin
        s_nxt.flags[FLAG_ERR] = 1'b1;
        s_nxt.st = TRPG_FAULT;
      // Timed ramps derive their step first
      end else if (s_r.cfg[OFS_MODE] == MODE_TIMED) begin
        s_nxt.st = TRPG_PREP;
      end else begin
        s_nxt.flags[FLAG_ON] = 1'b1;
        s_nxt.st = TRPG_ACCEL;
      end
    end else begin
      unique case (s_r.st)
        TRPG_PREP: begin
          // Step = span * 10 / ramp time in ms
          s_nxt.dvd = {s_r.dvd[DIV_W-2:0], 1'b0};
          s_nxt.rem = rem_t;
          if (rem_t >= DIV_W'(s_r.cfg[OFS_RAMP])) begin
            s_nxt.rem = rem_t - DIV_W'(s_r.cfg[OFS_RAMP]);
            s_nxt.dvd[0] = 1'b1;
          end
          s_nxt.iter = s_r.iter + 5'h1;
          if (s_r.iter == 5'(DIV_W - 1)) begin
            // Zero step would stall the ramp forever
            s_nxt.step = (s_nxt.dvd == '0) ? FREQ_W'(1)
                                           : s_nxt.dvd[FREQ_W-1:0];
            s_nxt.flags[FLAG_ON] = 1'b1;
            s_nxt.st = TRPG_ACCEL;
          end
        end
        TRPG_ACCEL, TRPG_STEADY, TRPG_DECEL: begin
          // Count rising edges, stop after the last high half
          if (toggle && !s_r.pulse) begin
            s_nxt.pcount = s_r.pcount + 32'h1;
            if (s_r.st == TRPG_ACCEL)
              s_nxt.accel_pulses = s_r.accel_pulses + 32'h1;
          end
          // Trapezoid: brake once the rest fits the climb
          if (s_r.st != TRPG_DECEL && remaining <= s_r.accel_pulses) begin
            s_nxt.st = TRPG_DECEL;
          end else if (s_r.st == TRPG_ACCEL && tick) begin
            if (up_sum >= {1'b0, f_steady}) begin
              s_nxt.freq = f_steady;
              s_nxt.st = TRPG_STEADY;
            end else begin
              s_nxt.freq = s_r.freq + s_r.step;
            end
          end
          if (s_r.st == TRPG_DECEL && tick) begin
            s_nxt.freq = ({1'b0, s_r.freq} <= dn_floor) ? f_init
                                                         : s_r.freq - s_r.step;
          end
          if (toggle && s_r.pulse && s_r.pcount == target) begin
            s_nxt.flags[FLAG_ON] = 1'b0;
            s_nxt.flags[FLAG_DONE] = 1'b1;
            s_nxt.st = TRPG_DONE;
          end
        end
        TRPG_IDLE, TRPG_DONE, TRPG_FAULT: begin
          s_nxt.pulse = 1'b0;
        end
        default: s_nxt.st = TRPG_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Single pulse pin, no direction pin
  assign ramp_pulse_output = s_r.pulse;
  assign status_flags = s_r.flags;
  assign reg_rdata = s_r.rdata;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_out_low_stop: assert property (!start |=> !ramp_pulse_output)
    else $error("pulse output high while start low");
  a_count_bound: assert property (running |-> s_r.pcount <= target)
    else $error("pulse count passed the preset");
  a_done_exact: assert property (
    s_r.st != TRPG_DONE ##1 s_r.st == TRPG_DONE |-> s_r.pcount == target)
    else $error("finished with wrong pulse count");
  a_steady_hold: assert property (
    s_r.st == TRPG_STEADY |-> s_r.freq == f_steady)
    else $error("steady phase off the steady frequency");
  a_accel_step: assert property (
    s_r.st == TRPG_ACCEL && tick && s_nxt.st == TRPG_ACCEL
    |=> s_r.freq == $past(s_r.freq) + s_r.step)
    else $error("acceleration step wrong");
  a_fresh_start: assert property (
    rise |=> s_r.pcount == 32'h0 && !s_r.flags[FLAG_DONE])
    else $error("new start did not reset the cycle");
  a_fault_entry: assert property (
    rise && check != ERR_NONE
    |=> s_r.st == TRPG_FAULT && s_r.err == $past(check))
    else $error("invalid words not reported");
  a_err_range: assert property (s_r.err <= 16'h000A)
    else $error("error code out of range");
  a_prep_len: assert property (
    s_r.st == TRPG_PREP ##1 s_r.st == TRPG_ACCEL
    |-> $past(s_r.iter) == 5'(DIV_W - 1))
    else $error("timed ramp divider too short");
  a_run_lo_read: assert property (
    reg_rd && rel == 8'(OFS_RUN_LO) && !s_r.swap
    |=> reg_rdata == $past(s_r.pcount[15:0]))
    else $error("running count low word readback wrong");
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == '0)
    else $error("read data not cleared after the read");
  a_err_timed: assert property (
    rise && s_r.cfg[OFS_MODE] == MODE_TIMED |=> s_r.err <= 16'h0009)
    else $error("timed mode error code out of range");
  a_decel_step: assert property (
    s_r.st == TRPG_DECEL && tick && start
    |=> s_r.freq < $past(s_r.freq) || s_r.freq == f_init)
    else $error("deceleration step wrong");
  a_fault_quiet: assert property (
    s_r.st == TRPG_FAULT |-> !ramp_pulse_output && !s_r.flags[FLAG_ON])
    else $error("pulses or run flag during a parameter fault");

  c_done: cover property (s_r.st == TRPG_DECEL ##1 s_r.st == TRPG_DONE);
  c_steady: cover property (s_r.st == TRPG_STEADY);
  c_fault: cover property (s_r.st == TRPG_FAULT);
  c_timed: cover property (s_r.st == TRPG_PREP ##1 s_r.st == TRPG_ACCEL);
  c_stopped: cover property (running && !start);
endmodule
`default_nettype wire

/* File: dv/trpg_drive_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Motor drive pulse input model
// ----------------------------------------
module trpg_drive_model (
  // Clock and pulse input
  input wire logic clk,
  input wire logic pulse,
  // Bench clear
  input wire logic clr,
  // Counts and high widths in clocks
  output int n_pulse,
  output int first_w,
  output int min_w,
  output int last_w
);
  int w;
  logic prev = 1'b0;
  // Drive counts on the rising edge, like an opto input
  always @(posedge clk) begin
    if (clr) begin
      n_pulse <= 0;
      first_w <= 0;
      min_w <= 1000000;
      w <= 0;
    end else if (pulse) begin
      w <= w + 1;
      if (!prev) n_pulse <= n_pulse + 1;
    end else if (prev) begin
      if (first_w == 0) first_w <= w;
      if (w < min_w) min_w <= w;
      last_w <= w;
      w <= 0;
    end
    prev <= pulse;
  end
endmodule
`default_nettype wire

/* File: dv/trpg_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(what, exp, got) \
  begin \
    n_checks++; \
    if ((got) !== (exp)) begin \
      n_errors++; \
      $display("FAIL %s exp %0h got %0h", what, exp, got); \
    end \
  end
module trpg_tb;
  import trpg_pkg::*;
  logic clk;
  logic reset_n;
  logic start_in;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [15:0] reg_rdata;
  logic ramp_pulse_output;
  logic [3:0] status_flags;
  logic clr;
  logic rd_d = 1'b0;
  logic seen;
  logic [15:0] s;
  logic [15:0] e_m;
  logic [15:0] mem [8];
  logic [15:0] exp_q [$];
  int n_errors = 0;
  int n_checks = 0;
  int n_pulse;
  int first_w;
  int min_w;
  int last_w;
  int k;
  logic [7:0] ew [7] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h07, 8'h01};
  logic [15:0] ev [7] = '{16'h4, 16'h0, 16'h65, 16'h0, 16'h1, 16'h0, 16'h28};

  trpg_top #(.TICK_CYCLES(50)) dut (
    .clk(clk), .reset_n(reset_n), .start_in(start_in),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ramp_pulse_output(ramp_pulse_output), .status_flags(status_flags)
  );
  trpg_drive_model drv (
    .clk(clk), .pulse(ramp_pulse_output), .clr(clr), .n_pulse(n_pulse),
    .first_w(first_w), .min_w(min_w), .last_w(last_w)
  );

  // ----------------------------------------
  // Bus tasks and read monitor
  // ----------------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask
  always @(posedge clk) begin
    rd_d <= reg_rd;
    if (rd_d) begin
      e_m = exp_q.pop_front();
      `CHK("reg_rdata", e_m, reg_rdata)
    end
  end
  task automatic cfg(input logic [15:0] m, input logic [15:0] st,
                     input logic [15:0] in, input logic [15:0] rp);
    wr(8'h00, m);
    wr(8'h01, st);
    wr(8'h02, in);
    wr(8'h03, rp);
    wr(8'h04, 16'h0000);
  endtask
  // Legal words loaded before start rises; each fault case then spoils one word
  task automatic base();
    cfg(16'h0002, 16'h0064, 16'h0032, 16'h0001);
    wr(8'h06, 16'h0000);
    wr(8'h07, 16'h0010);
  endtask
  task automatic run(input logic [15:0] w6, input logic [15:0] w7,
                     input int cnt, input int lim);
    wr(8'h06, w6);
    wr(8'h07, w7);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    start_in <= 1'b1;
    repeat (30) @(posedge clk);
    `CHK("on", 2'b01, status_flags[1:0])
    k = 0;
    while (status_flags[1] !== 1'b1 && k < lim) begin
      @(posedge clk);
      k++;
    end
    `CHK("run_time", 1'b1, 1'(k < lim))
    `CHK("pulses", cnt, n_pulse)
    `CHK("done", 2'b10, status_flags[1:0])
    rd(8'h08, w6);
    rd(8'h09, w7);
    rd(8'h0A, ERR_NONE);
    rd(8'h0B, 16'h0002);
    start_in <= 1'b0;
    repeat (5) @(posedge clk);
  endtask
  task automatic end_of_test();
    if (n_errors == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // ----------------------------------------
  // Clock, watchdog and main sequence
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    repeat (80000) @(posedge clk);
    n_errors++;
    end_of_test();
  end
  initial begin
    reset_n = 1'b0;
    start_in = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    clr = 1'b1;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    s = 16'h70B9;
    for (int i = 0; i < 11; i++) rd(8'(i), 16'h0000);
    for (int i = 0; i < 11; i++) begin
      s = lfsr(s);
      wr(8'(i), s);
      if (i < 8) mem[i] = s;
    end
    for (int i = 0; i < 11; i++) rd(8'(i), i < 8 ? mem[i] : 16'h0);
    rd(8'h20, 16'h0000);
    for (int i = 0; i < 7; i++) begin
      base();
      wr(ew[i], ev[i]);
      start_in <= 1'b1;
      repeat (8) @(posedge clk);
      `CHK("fault", 2'b10, {status_flags[3], ramp_pulse_output})
      rd(8'h0A, ERR_MODE + 16'(i));
      start_in <= 1'b0;
      repeat (5) @(posedge clk);
    end
    base();
    run(16'h0000, 16'h0010, 16, 20000);
    `CHK("steady_w", 1'b1, 1'(min_w >= 248 && min_w <= 252))
    `CHK("accel_w", 1'b1, 1'(first_w > 300 && first_w < 520))
    `CHK("decel_w", 1'b1, 1'(last_w > 300))
    for (int m = 1; m < 4; m++) begin
      if (m == 3) cfg(MODE_TIMED, 16'h2710, 16'h1388, 16'h000A);
      else cfg(16'(m), 16'h0064, 16'h0064, 16'h0001);
      run(16'h0000, 16'h0002, 2, 15000);
    end
    wr(8'h0C, 16'h0001);
    run(16'h0003, 16'h0000, 3, 6000);
    wr(8'h0C, 16'h0000);
    base();
    wr(8'h07, 16'h03E8);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    start_in <= 1'b1;
    @(posedge clk);
    k = 0;
    while (n_pulse < 3 && k < 5000) begin
      @(posedge clk);
      k++;
    end
    `CHK("stop_time", 1'b1, 1'(k < 5000))
    start_in <= 1'b0;
    repeat (4) @(posedge clk);
    `CHK("stop", 3'b010, {ramp_pulse_output, status_flags[1:0]})
    seen = 1'b0;
    repeat (200) begin
      @(posedge clk);
      seen = seen | ramp_pulse_output;
    end
    `CHK("held_low", 1'b0, seen)
    run(16'h0000, 16'h0002, 2, 6000);
    repeat (4) @(posedge clk);
    end_of_test();
  end
endmodule
`default_nettype wire
